// ==== hdl/autoneg_advert_id_regs.sv ====
/*
  identifier and copper advertisement register bank with the advertised
  code word that the negotiation engine transmits.
  assumes a plain register port with read data one cycle after the strobe,
  and a copper link status level from the line side.
*/
`timescale 1ns/100ps
module autoneg_advert_id_regs
  import advert_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DW-1:0] reg_rdata,
  // line side
  input wire logic copper_link,
  input wire logic [3:0] low_abilities,
  input wire logic [1:0] gig_abilities,
  // negotiation engine side
  output logic [REG_DW-1:0] base_code_word,
  output logic [1:0] gig_code,
  output logic send_extra_pages,
  output logic an_active,
  output logic adv_commit
);
  // ***********************************
  // state
  // ***********************************
  logic [ADV_HI_W-1:0] pending;
  logic [ADV_HI_W-1:0] active;
  logic [CTL_W-1:0] ctrl;
  logic power_down_q;
  logic link_level;
  logic link_fall;
  logic soft_reset_p;
  logic restart_p;
  logic power_up_p;
  logic [ADV_HI_W-1:0] next_pending;
  logic [REG_DW-1:0] next_rdata;
  logic forced_gig;
  logic [REG_DW-1:0] id_word;
  logic wr_adv;
  logic wr_ctl;

  assign wr_adv = reg_wr && (reg_addr == OFF_COPPER_ADVERT);
  assign wr_ctl = reg_wr && (reg_addr == OFF_ADVERT_CTRL);
  assign soft_reset_p = wr_ctl && reg_wdata[CTL_SOFT_RESET];
  assign restart_p = wr_ctl && reg_wdata[CTL_RESTART_AN];
  assign power_up_p = power_down_q && !ctrl[CTL_POWER_DOWN];
  assign forced_gig = !ctrl[CTL_AN_ENABLE] && ctrl[CTL_SPEED_1000];
  assign id_word = {ORG_ID_LOW_BITS, MODEL_NUMBER, REVISION_NUMBER};

  // ***********************************
  // link level crossing
  // ***********************************
  link_sync u_link_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(copper_link),
    .sync_out(link_level),
    .fall(link_fall)
  );

  // ***********************************
  // pending advertisement byte
  // ***********************************
  always_comb begin
    next_pending = pending;
    if (wr_adv) begin
      // ack and t4 stay zero; reserved bit stays writable
      next_pending = reg_wdata[REG_DW-1:ADV_HI_LSB] & ADV_HI_WMASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= ADV_HI_RESET;
    end else begin
      pending <= next_pending;
    end
  end

  advert_commit u_commit (
    .mclk(mclk),
    .rst_n(rst_n),
    .soft_reset(soft_reset_p),
    .restart_an(restart_p),
    .power_up(power_up_p),
    .link_drop(link_fall),
    .pending(pending),
    .active(active)
  );

  // ***********************************
  // control register (self-clearing pulses)
  // ***********************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTL_RESET;
      power_down_q <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctrl <= reg_wdata[CTL_W-1:0];
        ctrl[CTL_SOFT_RESET] <= 1'b0;
        ctrl[CTL_RESTART_AN] <= 1'b0;
      end
      power_down_q <= ctrl[CTL_POWER_DOWN];
    end
  end

  // ***********************************
  // code word toward the negotiation engine
  // ***********************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      base_code_word <= '0;
      gig_code <= '0;
      send_extra_pages <= 1'b0;
      an_active <= 1'b0;
      adv_commit <= 1'b0;
    end else begin
      adv_commit <= soft_reset_p || restart_p || power_up_p || link_fall;
      an_active <= ctrl[CTL_AN_ENABLE] || forced_gig;
      base_code_word[ADV_NEXT_PAGE] <= active[ADV_NEXT_PAGE-ADV_HI_LSB];
      base_code_word[ADV_ACK] <= 1'b0;
      base_code_word[ADV_REMOTE_FAULT] <= active[ADV_REMOTE_FAULT-ADV_HI_LSB];
      base_code_word[ADV_RESERVED] <= active[ADV_RESERVED-ADV_HI_LSB];
      base_code_word[ADV_ASYM_PAUSE] <= active[ADV_ASYM_PAUSE-ADV_HI_LSB];
      base_code_word[ADV_PAUSE] <= active[ADV_PAUSE-ADV_HI_LSB];
      base_code_word[ADV_T4] <= 1'b0;
      if (forced_gig) begin
        base_code_word[ADV_TX_FD:0] <= '0;
        gig_code <= ctrl[CTL_FULL_DUPLEX] ? 2'b10 : 2'b01;
      end else begin
        base_code_word[ADV_TX_FD] <= active[ADV_TX_FD-ADV_HI_LSB];
        base_code_word[ADV_TX_FD-1:ADV_TX_FD-4] <= low_abilities;
        base_code_word[ADV_TX_FD-5:0] <= '0;
        gig_code <= gig_abilities;
      end
      // extra gigabit pages go out whenever gigabit is advertised
      send_extra_pages <= forced_gig || (gig_abilities != 2'b00);
    end
  end

  // ***********************************
  // read path
  // ***********************************
  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      OFF_PHY_ID_LOW: next_rdata = id_word;
      OFF_COPPER_ADVERT: next_rdata = {pending, 8'h00};
      OFF_ADVERT_CTRL: next_rdata = {9'h000, ctrl};
      OFF_ADVERT_STATUS: next_rdata = {7'h00, link_level, active};
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : autoneg_advert_id_regs

// ==== hdl/advert_pkg.sv ====
/*
  constants for the identifier and advertisement register bank:
  offsets, field positions, reset values and identity fields.
  assumes a 16-bit management register space reached by word index.
*/
package advert_pkg;
  localparam int REG_AW = 5;
  localparam int REG_DW = 16;
  // ***********************************
  // register offsets
  // ***********************************
  localparam logic [4:0] OFF_PHY_ID_LOW = 5'h03;
  localparam logic [4:0] OFF_COPPER_ADVERT = 5'h04;
  localparam logic [4:0] OFF_ADVERT_CTRL = 5'h10;
  localparam logic [4:0] OFF_ADVERT_STATUS = 5'h11;
  // ***********************************
  // identifier fields (values arbitrary)
  // ***********************************
  localparam logic [5:0] ORG_ID_LOW_BITS = 6'h2A;
  localparam logic [5:0] MODEL_NUMBER = 6'h15;
  localparam logic [3:0] REVISION_NUMBER = 4'h1;
  localparam int ID_ORG_LSB = 10;
  localparam int ID_MODEL_LSB = 4;
  // ***********************************
  // advertisement bit positions
  // ***********************************
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_ACK = 14;
  localparam int ADV_REMOTE_FAULT = 13;
  localparam int ADV_RESERVED = 12;
  localparam int ADV_ASYM_PAUSE = 11;
  localparam int ADV_PAUSE = 10;
  localparam int ADV_T4 = 9;
  localparam int ADV_TX_FD = 8;
  localparam int ADV_HI_LSB = 8;
  localparam int ADV_HI_W = 8;
  // writable mask of the upper byte: ack and t4 are fixed at zero
  localparam logic [7:0] ADV_HI_WMASK = 8'hBD;
  localparam logic [7:0] ADV_HI_RESET = 8'h01;
  // ***********************************
  // own control register fields
  // ***********************************
  localparam int CTL_SOFT_RESET = 0;
  localparam int CTL_RESTART_AN = 1;
  localparam int CTL_POWER_DOWN = 2;
  localparam int CTL_AN_ENABLE = 3;
  localparam int CTL_SPEED_1000 = 4;
  localparam int CTL_FULL_DUPLEX = 5;
  localparam int CTL_EXTRA_PAGES = 6;
  localparam logic [6:0] CTL_RESET = 7'h08;
  localparam int CTL_W = 7;
endpackage : advert_pkg

// ==== hdl/link_sync.sv ====
/*
  three-flop synchroniser for the copper link level.
  assumes a level from another clock domain.
*/
`timescale 1ns/100ps
module link_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // level
  input wire logic async_in,
  output logic sync_out,
  output logic fall
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      // a change counts once the second and third flops agree
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end
  assign fall = sync_out && (s2 == s3) && !s3;
endmodule : link_sync

// ==== hdl/advert_commit.sv ====
/*
  pending to active transfer of the advertisement byte.
  assumes one-cycle trigger pulses on the same clock.
*/
`timescale 1ns/100ps
module advert_commit
  import advert_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // triggers
  input wire logic soft_reset,
  input wire logic restart_an,
  input wire logic power_up,
  input wire logic link_drop,
  // values
  input wire logic [ADV_HI_W-1:0] pending,
  output logic [ADV_HI_W-1:0] active
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active <= ADV_HI_RESET;
    end else if (soft_reset || restart_an || power_up || link_drop) begin
      active <= pending;
    end
  end
endmodule : advert_commit

// ==== sim/autoneg_advert_id_regs_asserts.sv ====
/*
  checker for the identifier and advertisement register bank.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module autoneg_advert_id_regs_asserts
  import advert_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [REG_DW-1:0] reg_rdata,
  // engine side
  input wire logic [REG_DW-1:0] base_code_word,
  input wire logic adv_commit
);
  logic [7:0] wr_hi;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // last upper byte written to the advertisement word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_hi <= ADV_HI_RESET;
    end else if (reg_wr && reg_addr == OFF_COPPER_ADVERT) begin
      wr_hi <= reg_wdata[15:8] & ADV_HI_WMASK;
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside the read slot");
  a_id_read: assert property ($past(reg_rd) && $past(reg_addr) == OFF_PHY_ID_LOW
    |-> reg_rdata == {ORG_ID_LOW_BITS, MODEL_NUMBER, REVISION_NUMBER})
    else $error("identifier word wrong");
  a_adv_fixed: assert property ($past(reg_rd) && $past(reg_addr) == OFF_COPPER_ADVERT
    |-> reg_rdata[14] == 1'b0 && reg_rdata[9] == 1'b0 && reg_rdata[7:0] == 8'h00)
    else $error("fixed advertisement bits not zero");
  a_adv_readback: assert property ($past(reg_rd) && $past(reg_addr) == OFF_COPPER_ADVERT
    |-> reg_rdata[15:8] == wr_hi)
    else $error("advertisement read differs from last write");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 5'h1F
    |-> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_commit_pulse: assert property (adv_commit |=> !adv_commit)
    else $error("commit pulse longer than one cycle");
  a_ack_low: assert property (base_code_word[14] == 1'b0)
    else $error("acknowledge bit set in base word");
  a_t4_low: assert property (base_code_word[9] == 1'b0)
    else $error("four-pair bit set in base word");
endmodule : autoneg_advert_id_regs_asserts

bind autoneg_advert_id_regs autoneg_advert_id_regs_asserts i_autoneg_advert_id_regs_asserts (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .base_code_word(base_code_word),
  .adv_commit(adv_commit));

// ==== sim/autoneg_advert_id_regs_bench.sv ====
/*
  self-checking bench for the register bank.
  assumes the checker is bound in and the line side is driven here.
*/
`timescale 1ns/100ps
module autoneg_advert_id_regs_bench;
  import advert_pkg::*;
  logic mclk = 0;
  logic rst_n = 0;
  logic [4:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic copper_link = 1;
  logic [15:0] reg_rdata, base_code_word;
  logic [1:0] gig_code;
  logic send_extra_pages, an_active, adv_commit;
  int errors = 0;
  int checks = 0;
  localparam logic [15:0] ID = {ORG_ID_LOW_BITS, MODEL_NUMBER, REVISION_NUMBER};
  always #2 mclk = ~mclk;
  autoneg_advert_id_regs i_autoneg_advert_id_regs (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .copper_link(copper_link), .low_abilities(4'hA),
    .gig_abilities(2'b01), .base_code_word(base_code_word), .gig_code(gig_code),
    .send_extra_pages(send_extra_pages), .an_active(an_active), .adv_commit(adv_commit));
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(logic [4:0] a, logic [15:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    #1;
    chk("read data", reg_rdata, exp);
  endtask : rd
  task automatic wait_commit();
    int n;
    n = 0;
    // the commit pulse stands one cycle, so look once it has settled
    #1;
    while (adv_commit !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 40) begin
      errors++;
      conclude();
    end
    repeat (3) @(posedge mclk);
  endtask : wait_commit
  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    rd(OFF_PHY_ID_LOW, ID);
    rd(OFF_COPPER_ADVERT, 16'h0100);
    wr(OFF_PHY_ID_LOW, 16'h0000);
    rd(OFF_PHY_ID_LOW, ID);
    wr(OFF_COPPER_ADVERT, 16'hFFFF);
    rd(OFF_COPPER_ADVERT, 16'hBD00);
    rd(OFF_ADVERT_STATUS, 16'h0101);
    rd(5'h1F, 16'h0000);
    wr(OFF_ADVERT_CTRL, 16'h000A);
    wait_commit();
    rd(OFF_ADVERT_STATUS, 16'h01BD);
    chk("base word", {4'h0, base_code_word[15:4]}, 16'h0BDA);
    wr(OFF_COPPER_ADVERT, 16'h0000);
    copper_link <= 0;
    wait_commit();
    rd(OFF_ADVERT_STATUS, 16'h0000);
    copper_link <= 1;
    wr(OFF_ADVERT_CTRL, 16'h000C);
    wr(OFF_COPPER_ADVERT, 16'h0400);
    wr(OFF_ADVERT_CTRL, 16'h0008);
    wait_commit();
    rd(OFF_ADVERT_STATUS, 16'h0104);
    wr(OFF_COPPER_ADVERT, 16'h0800);
    wr(OFF_ADVERT_CTRL, 16'h0009);
    wait_commit();
    rd(OFF_ADVERT_STATUS, 16'h0108);
    wr(OFF_ADVERT_CTRL, 16'h0032);
    wait_commit();
    chk("forced code", {13'h0, an_active, gig_code}, 16'h0006);
    chk("forced low bits", {7'h0, base_code_word[8:0]}, 16'h0000);
    chk("extra pages", {15'h0, send_extra_pages}, 16'h0001);
    wr(OFF_ADVERT_CTRL, 16'h0012);
    wait_commit();
    chk("forced half", {14'h0, gig_code}, 16'h0001);
    conclude();
  end
endmodule : autoneg_advert_id_regs_bench
